// ===== arbiter_map.vh
// Register offsets, field positions and constants of the serial bus arbiter
`ifndef ARBITER_MAP_VH
`define ARBITER_MAP_VH
`define ADDR_CTRL 1'b0
`define ADDR_DATA 1'b1
`define BIT_MODE_LO 0
`define BIT_MODE_HI 1
`define BIT_TOP 2
`define BIT_OVF 3
`define BIT_RUN 4
`define BIT_DONE 5
`define BIT_CLKSEL 6
`define BIT_LOST 7
`define MODE_IDLE 2'b00
`define MODE_MEAS 2'b01
`define MODE_ARB 2'b10
`define SAMPLE_BUS 9'h038
`define SAMPLE_PRE 9'h008
`define BUS_DIV 2'h3
`endif

// ===== serial_bus_arbiter_counter.v
// Serial bus arbiter: 9-bit counter for bit timing and bus arbitration
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
`include "arbiter_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - 9-bit counter with overflow bit, sequenced by mode control logic.
// - Mode 00 idle and reset, 01 bit time measurement, 10 arbitration.
// - Mode field read/write; reset clears it to idle.
// - Arbitration lost clears on write of zero to upper mode bit, or reset.
// - Clock select 1 uses half prescaler clock, 0 bus clock over four.
// - Prescaler runs from bus clock or crystal clock per config bit.
// - Measurement done set on completion; cleared by control write or reset.
// - Running flag reads 1 while counting; reset clears it.
// - Overflow flag shows counter overflow; control write or reset clears it.
// - Mode 00 holds counter in reset while selected.
// - Counter top bit readable in control register; control write or reset clears.
// - Low eight counter bits readable in data register; control write or reset clears.
// - Bus clock measurement runs between two falling receive edges.
// - Prescaler measurement runs from receive low to next rising edge.
// - Receive already low at enable with prescaler source starts at once.
// - Arbitration starts counter on each rising internal transmit edge.
// - At 0x38 or 0x08 sample receive; low sets arbitration lost.
// - Arbitration lost forces transmit pin high.
// - Transmit low before receive low resets counter, awaiting next rise.
module serial_bus_arbiter_counter
(
    // Clock, reset, enable
    input wire clock,
    input wire rstn,
    input wire clock_en,
    // Avalon-MM slave
    input wire address,
    input wire read,
    input wire write,
    input wire [7:0] writedata,
    output reg [7:0] readdata,
    output reg waitrequest,
    // Clock sources
    input wire crystal_clock,
    input wire baud_clock_source_select,
    input wire prescaler_tick,
    // Serial lines
    input wire rxd_pin,
    input wire internal_transmit_output,
    output reg txd_pin
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg rx_meta_reg;
reg rx_sync_reg;
reg rx_prev_reg;
reg xc_meta_reg;
reg xc_sync_reg;
reg xc_prev_reg;
reg pt_meta_reg;
reg pt_sync_reg;
reg pt_prev_reg;

// Receive line idles high; resetting the chain high avoids a false edge
always @(posedge clock)
begin
    if (!rstn)
    begin
        rx_meta_reg <= 1'b1;
        rx_sync_reg <= 1'b1;
        rx_prev_reg <= 1'b1;
    end
    else if (clock_en)
    begin
        rx_meta_reg <= rxd_pin;
        rx_sync_reg <= rx_meta_reg;
        rx_prev_reg <= rx_sync_reg;
    end
end

// Crystal and prescaler pins are slow clocks, sampled only for their edges
always @(posedge clock)
begin
    if (!rstn)
    begin
        xc_meta_reg <= 1'b0;
        xc_sync_reg <= 1'b0;
        xc_prev_reg <= 1'b0;
        pt_meta_reg <= 1'b0;
        pt_sync_reg <= 1'b0;
        pt_prev_reg <= 1'b0;
    end
    else if (clock_en)
    begin
        xc_meta_reg <= crystal_clock;
        xc_sync_reg <= xc_meta_reg;
        xc_prev_reg <= xc_sync_reg;
        pt_meta_reg <= prescaler_tick;
        pt_sync_reg <= pt_meta_reg;
        pt_prev_reg <= pt_sync_reg;
    end
end

wire rx_fall = rx_prev_reg & ~rx_sync_reg;
wire rx_rise = ~rx_prev_reg & rx_sync_reg;
wire xc_rise = ~xc_prev_reg & xc_sync_reg;
wire pt_rise = ~pt_prev_reg & pt_sync_reg;

////////////////////////////////////////////////////////////////////////////////
// Helpers

// Sample point of arbitration depends on the counter clock source
function at_sample_point;
    input [8:0] count;
    input clk_sel;
    begin
        if (clk_sel)
            at_sample_point = (count == `SAMPLE_PRE);
        else
            at_sample_point = (count == `SAMPLE_BUS);
    end
endfunction

// Counter advance; the carry is dropped here and flagged by the caller
function [8:0] count_plus_one;
    input [8:0] count;
    begin
        count_plus_one = count + 9'h001;
    end
endfunction

// Status byte as software reads it
function [7:0] status_image;
    input lost;
    input clk_sel;
    input done;
    input run;
    input ovf;
    input top;
    input [1:0] mode;
    begin
        status_image = {lost, clk_sel, done, run, ovf, top, mode};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Register state
reg [1:0] mode_reg;
reg clk_sel_reg;
reg lost_reg;
reg done_reg;
reg run_reg;
reg ovf_reg;
reg [8:0] count_reg;
reg tx_prev_reg;
reg armed_reg;
reg meas_seen_reg;
reg [1:0] bus_div_reg;
reg pre_half_reg;

////////////////////////////////////////////////////////////////////////////////
// Decoded events
wire bus_access = (read | write) & waitrequest;
wire ctrl_wr = write & ~waitrequest & (address == `ADDR_CTRL);

// Crystal edges stand in for the prescaler output when the crystal feeds it
wire pre_tick = baud_clock_source_select ? xc_rise : pt_rise;
wire pre_step = pre_tick & pre_half_reg;
wire bus_step = (bus_div_reg == `BUS_DIV);
wire cnt_step = clk_sel_reg ? pre_step : bus_step;

// Internal transmit output is same-clock logic and needs no synchroniser
wire tx_rise = internal_transmit_output & ~tx_prev_reg;

wire meas_mode = (mode_reg == `MODE_MEAS);
wire arb_mode = (mode_reg == `MODE_ARB);

wire meas_start = meas_mode & ~run_reg & ~meas_seen_reg &
    (clk_sel_reg ? ~rx_sync_reg : rx_fall);
wire meas_stop = meas_mode & run_reg & (clk_sel_reg ? rx_rise : rx_fall);
wire meas_step = meas_mode & run_reg & ~meas_stop & cnt_step;

wire arb_start = arb_mode & tx_rise;
wire arb_abort = arb_mode & ~tx_rise & armed_reg & ~internal_transmit_output &
    rx_sync_reg;
wire arb_sample = arb_mode & ~tx_rise & ~arb_abort & run_reg &
    at_sample_point(count_reg, clk_sel_reg);
wire arb_step = arb_mode & ~tx_rise & ~arb_abort & run_reg & ~arb_sample &
    cnt_step;

wire lost_set = arb_sample & ~rx_sync_reg;
// Carry out of the top count while measuring
wire ovf_set = meas_step & (count_reg == 9'h1ff);

////////////////////////////////////////////////////////////////////////////////
// Counter clock dividers
// Bus divider free-runs, so a measurement may start mid-phase: up to one step lost
always @(posedge clock)
begin
    if (!rstn)
    begin
        bus_div_reg <= 2'h0;
        pre_half_reg <= 1'b0;
    end
    else if (clock_en)
    begin
        bus_div_reg <= bus_div_reg + 2'h1;
        if (pre_tick)
            pre_half_reg <= ~pre_half_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Avalon-MM slave: one wait state per access
// Answer is registered so every output stays a flip-flop, at one cycle of latency
always @(posedge clock)
begin
    if (!rstn)
    begin
        waitrequest <= 1'b1;
        readdata <= 8'h00;
    end
    else if (clock_en)
    begin
        waitrequest <= ~bus_access;
        if (read & waitrequest)
        begin
            if (address == `ADDR_CTRL)
                readdata <= status_image(lost_reg, clk_sel_reg, done_reg, run_reg,
                    ovf_reg, count_reg[8], mode_reg);
            else
                readdata <= count_reg[7:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Mode and clock select; reserved mode 11 is stored but counts nothing
always @(posedge clock)
begin
    if (!rstn)
    begin
        mode_reg <= `MODE_IDLE;
        clk_sel_reg <= 1'b0;
    end
    else if (clock_en && ctrl_wr)
    begin
        mode_reg <= writedata[`BIT_MODE_HI:`BIT_MODE_LO];
        clk_sel_reg <= writedata[`BIT_CLKSEL];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Previous transmit level; resets to the idle high so reset makes no false rise
always @(posedge clock)
begin
    if (!rstn)
        tx_prev_reg <= 1'b1;
    else if (clock_en)
        tx_prev_reg <= internal_transmit_output;
end

////////////////////////////////////////////////////////////////////////////////
// Counter, running flag and arbitration arming
always @(posedge clock)
begin
    if (!rstn)
    begin
        count_reg <= 9'h000;
        run_reg <= 1'b0;
        armed_reg <= 1'b0;
        meas_seen_reg <= 1'b0;
    end
    else if (clock_en)
    begin
        if (ctrl_wr)
        begin
            count_reg <= 9'h000;
            run_reg <= 1'b0;
            armed_reg <= 1'b0;
            meas_seen_reg <= 1'b0;
        end
        else
        begin
            case (mode_reg)
                `MODE_IDLE:
                begin
                    count_reg <= 9'h000;
                    run_reg <= 1'b0;
                    armed_reg <= 1'b0;
                    meas_seen_reg <= 1'b0;
                end
                `MODE_MEAS:
                begin
                    if (meas_start)
                    begin
                        run_reg <= 1'b1;
                        meas_seen_reg <= 1'b1;
                    end
                    else if (meas_stop)
                        run_reg <= 1'b0;
                    else if (meas_step)
                        count_reg <= count_plus_one(count_reg);
                end
                `MODE_ARB:
                begin
                    if (arb_start)
                    begin
                        count_reg <= 9'h000;
                        run_reg <= 1'b1;
                        armed_reg <= 1'b1;
                    end
                    else if (arb_abort)
                    begin
                        count_reg <= 9'h000;
                        run_reg <= 1'b0;
                        armed_reg <= 1'b0;
                    end
                    else if (arb_sample)
                    begin
                        run_reg <= 1'b0;
                        armed_reg <= 1'b0;
                    end
                    else if (arb_step)
                        count_reg <= count_plus_one(count_reg);
                end
                default:
                begin
                    // Reserved code: counter holds, nothing runs
                    run_reg <= 1'b0;
                    armed_reg <= 1'b0;
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Status flags: a hardware event in the same cycle as a clearing write wins
always @(posedge clock)
begin
    if (!rstn)
    begin
        done_reg <= 1'b0;
        ovf_reg <= 1'b0;
        lost_reg <= 1'b0;
    end
    else if (clock_en)
    begin
        if (meas_stop)
            done_reg <= 1'b1;
        else if (ctrl_wr)
            done_reg <= 1'b0;

        if (ovf_set)
            ovf_reg <= 1'b1;
        else if (ctrl_wr)
            ovf_reg <= 1'b0;

        if (lost_set)
            lost_reg <= 1'b1;
        else if (ctrl_wr && !writedata[`BIT_MODE_HI])
            lost_reg <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Transmit pin: a lost arbitration holds the line recessive
always @(posedge clock)
begin
    if (!rstn)
        txd_pin <= 1'b1;
    else if (clock_en)
        txd_pin <= internal_transmit_output | lost_reg;
end

endmodule

// ===== arb_monitor.sv
// Port checker for the serial bus arbiter
`timescale 1ns/10ps
module arb_monitor
(
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Register bus
    input wire read,
    input wire write,
    input wire [7:0] readdata,
    input wire waitrequest,
    // Serial lines
    input wire internal_transmit_output,
    input wire txd_pin
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    ////////////////////
    // Answer lasts one cycle so the master cannot take it twice
    property p_one; !waitrequest |=> waitrequest; endproperty
    a_one: assert property (p_one) else $error("answer too long");
    property p_cause; !waitrequest |-> $past(read || write); endproperty
    a_cause: assert property (p_cause) else $error("answer unasked");
    property p_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("answer late");
    property p_rise; $rose(read) || $rose(write) |-> ##[1:2] !waitrequest; endproperty
    a_rise: assert property (p_rise) else $error("no answer");
    property p_hold; $changed(readdata) |-> $past(read); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rst; $rose(rstn) |-> waitrequest && txd_pin && readdata == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_txh; internal_transmit_output |=> txd_pin; endproperty
    a_txh: assert property (p_txh) else $error("txd not high");
    property p_txl; !txd_pin |-> !$past(internal_transmit_output); endproperty
    a_txl: assert property (p_txl) else $error("txd low wrongly");
endmodule
bind serial_bus_arbiter_counter arb_monitor i_mon
(
    .clock(clock),
    .rstn(rstn),
    .read(read),
    .write(write),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .internal_transmit_output(internal_transmit_output),
    .txd_pin(txd_pin)
);

// ===== bus_node.sv
// Another node on the shared serial line
`timescale 1ns/10ps
module bus_node
(
    // Bus side
    input wire txd_pin,
    input wire dominant,
    output wire rxd_pin
);
    // Wired-AND line: any node pulling low wins
    assign rxd_pin = txd_pin & ~dominant;
endmodule

// ===== serial_bus_arbiter_counter_bench.sv
// Register-level bench for the serial bus arbiter
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module serial_bus_arbiter_counter_bench;
    logic clock = 0, rstn = 0, address = 0, read = 0, write = 0, itx = 1, dom = 0;
    logic bsel = 0;
    logic [7:0] writedata = 8'h00;
    logic [7:0] rv;
    logic [2:0] pc = 3'h0;
    wire [7:0] readdata;
    wire waitrequest, txd_pin, rxd_pin;
    int err_count = 0, tests_run = 0;
    initial forever #12.5 clock = ~clock;
    // Slow prescaler and crystal stand-ins
    always @(posedge clock) pc <= pc + 3'h1;
    serial_bus_arbiter_counter i_dut (.clock(clock), .rstn(rstn), .clock_en(1'b1),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .crystal_clock(pc[1]),
        .baud_clock_source_select(bsel), .prescaler_tick(pc[2]), .rxd_pin(rxd_pin),
        .internal_transmit_output(itx), .txd_pin(txd_pin));
    bus_node i_node (.txd_pin(txd_pin), .dominant(dom), .rxd_pin(rxd_pin));
    ////////////////////
    task close_out;
        $display("mismatches %0d of %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task acc(input logic a, input logic w, input logic [7:0] d);
        int n;
        @(posedge clock);
        address <= a;
        write <= w;
        read <= ~w;
        writedata <= d;
        @(posedge clock);
        for (n = 0; waitrequest !== 1'b0 && n < 20; n++) @(posedge clock);
        rv = readdata;
        read <= 1'b0;
        write <= 1'b0;
        `CHK("wait", 1'b1, n < 20)
        if (n == 20)
            close_out();
    endtask
    task rd(input logic a, input logic [7:0] e, input logic [7:0] m);
        acc(a, 1'b0, 8'h00);
        `CHK("reg", e, rv & m)
    endtask
    task tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    ////////////////////
    initial
    begin
        tick(20);
        rstn <= 1'b1;
        rd(1'b0, 8'h00, 8'hff);
        rd(1'b1, 8'h00, 8'hff);
        // Bus clock measurement, edges 100 cycles apart
        acc(1'b0, 1'b1, 8'h01);
        dom <= 1'b1;
        tick(10);
        dom <= 1'b0;
        tick(88);
        rd(1'b0, 8'h10, 8'h30);
        dom <= 1'b1;
        tick(10);
        rd(1'b0, 8'h20, 8'h30);
        rd(1'b1, 8'h00, 8'h00);
        `CHK("count", 1'b1, rv > 8'h17 && rv < 8'h1b)
        dom <= 1'b0;
        acc(1'b0, 1'b1, 8'h00);
        rd(1'b0, 8'h00, 8'hff);
        rd(1'b1, 8'h00, 8'hff);
        // Long low level wraps the counter
        acc(1'b0, 1'b1, 8'h01);
        dom <= 1'b1;
        tick(2100);
        dom <= 1'b0;
        rd(1'b0, 8'h08, 8'h08);
        acc(1'b0, 1'b1, 8'h00);
        rd(1'b0, 8'h00, 8'h08);
        // Prescaler source with the line already low
        dom <= 1'b1;
        acc(1'b0, 1'b1, 8'h41);
        tick(100);
        rd(1'b0, 8'h50, 8'h70);
        dom <= 1'b0;
        tick(20);
        rd(1'b0, 8'h20, 8'h30);
        rd(1'b1, 8'h00, 8'h00);
        `CHK("pre", 1'b1, rv > 8'h03 && rv < 8'h0b)
        // Crystal feeding the prescaler steps twice as fast here
        bsel <= 1'b1;
        dom <= 1'b1;
        acc(1'b0, 1'b1, 8'h41);
        tick(100);
        dom <= 1'b0;
        tick(20);
        rd(1'b0, 8'h20, 8'h30);
        rd(1'b1, 8'h00, 8'h00);
        `CHK("xtal", 1'b1, rv > 8'h0a && rv < 8'h12)
        bsel <= 1'b0;
        // Arbitration lost while another node drives low
        acc(1'b0, 1'b1, 8'h02);
        itx <= 1'b0;
        tick(5);
        itx <= 1'b1;
        dom <= 1'b1;
        tick(300);
        rd(1'b0, 8'h80, 8'h80);
        itx <= 1'b0;
        tick(4);
        `CHK("txd", 1'b1, txd_pin)
        dom <= 1'b0;
        acc(1'b0, 1'b1, 8'h00);
        rd(1'b0, 8'h00, 8'h80);
        // Own low bit before any sample restarts arbitration
        acc(1'b0, 1'b1, 8'h02);
        itx <= 1'b1;
        tick(20);
        itx <= 1'b0;
        tick(5);
        itx <= 1'b1;
        tick(300);
        rd(1'b0, 8'h02, 8'h83);
        rd(1'b1, 8'h38, 8'hff);
        itx <= 1'b0;
        tick(4);
        `CHK("txd", 1'b0, txd_pin)
        close_out();
    end
endmodule
